// file: verilog/sppc_defs.svh
// Register offsets, field positions and reset values of the serial pin and priority control block.
`ifndef SPPC_DEFS_SVH
`define SPPC_DEFS_SVH
// Registers are indexed by word; the bus byte address is four times the index.
`define SPPC_PIN_CTL_IDX 16'h105E
`define SPPC_PRI_CTL_IDX 16'h105F
`define SPPC_PIN_CTL_ADDR 15'h4178
`define SPPC_PRI_CTL_ADDR 15'h417C
`define SPPC_ADDR_W 15
`define SPPC_RX_DIR_BIT 0
`define SPPC_RX_FUNC_BIT 1
`define SPPC_RX_OUT_BIT 2
`define SPPC_RX_IN_BIT 3
`define SPPC_TX_DIR_BIT 4
`define SPPC_TX_FUNC_BIT 5
`define SPPC_TX_OUT_BIT 6
`define SPPC_TX_IN_BIT 7
`define SPPC_SUSPEND_EN_BIT 4
`define SPPC_RXPRI_BIT 5
`define SPPC_TXPRI_BIT 6
`define SPPC_PORT_TEST_BIT 7
`define SPPC_PIN_RW_MASK 8'h77
`define SPPC_PRI_RW_MASK 8'hF0
`define SPPC_RESET_VAL 8'h00
`define SPPC_RESP_OKAY 2'h0
`define SPPC_RESP_SLVERR 2'h2
`endif

// file: verilog/sppc_pkg.sv
// Types shared by the serial pin and priority control block.
package sppc_pkg;
  typedef enum logic [1:0] {
    SPPC_W_IDLE,
    SPPC_W_RESP
  } sppc_wstate_type;
  typedef enum logic [1:0] {
    SPPC_R_IDLE,
    SPPC_R_RESP
  } sppc_rstate_type;
endpackage : sppc_pkg

// file: verilog/sppc_pin_sync.sv
// Two-flop synchroniser for the two data pin input levels.
`timescale 1ns/1ps
module sppc_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sppc_sync_type;
  sppc_sync_type st_r;
  sppc_sync_type st_nxt;
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sync_out = st_r.sync;
endmodule : sppc_pin_sync

// file: verilog/sppc_pin_drive.sv
// Pin driver: picks general-purpose or serial engine drive for one data pin.
`timescale 1ns/1ps
module sppc_pin_drive (
  input wire logic gp_func_n, // 0 = general purpose, 1 = serial engine.
  input wire logic gp_dir, // 1 = general-purpose output.
  input wire logic gp_out, // General-purpose output value.
  input wire logic eng_out, // Serial engine output value.
  input wire logic eng_oe_n, // Serial engine output enable, active low.
  output logic pin_out, // Pin output value.
  output logic pin_oe_n // Pin output enable, active low.
);
  always_comb begin
    if (gp_func_n) begin
      pin_out = eng_out;
      pin_oe_n = eng_oe_n;
    end else begin
      pin_out = gp_out;
      pin_oe_n = ~gp_dir;
    end
  end
endmodule : sppc_pin_drive

// file: verilog/sppc_top.sv
// Serial port data pin and interrupt priority control with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "sppc_defs.svh"
module sppc_top (
  input wire logic aclk, // System clock, 25 MHz.
  input wire logic aresetn, // Synchronous system reset, active low.
  input wire logic [`SPPC_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic [2:0] s_axi_awprot, // Write protection; bit 0 marks privileged.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [`SPPC_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic [2:0] s_axi_arprot, // Read protection, unused.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic privileged_mode, // CPU privileged state, same clock domain.
  input wire logic emu_suspend, // Emulation suspend request level, same clock domain.
  input wire logic port_busy, // Serial engine is mid transmit or receive sequence.
  input wire logic receive_data_pin_in, // Receive pin level from pad.
  output logic receive_data_pin_out, // Receive pin drive value.
  output logic receive_data_pin_oe_n, // Receive pin output enable, active low.
  input wire logic transmit_data_pin_in, // Transmit pin level from pad.
  output logic transmit_data_pin_out, // Transmit pin drive value.
  output logic transmit_data_pin_oe_n, // Transmit pin output enable, active low.
  input wire logic tx_engine_out, // Transmitter serial output.
  output logic rx_engine_in, // Receive pin level to receiver.
  input wire logic rx_irq_req, // Receiver interrupt request.
  input wire logic tx_irq_req, // Transmitter interrupt request.
  output logic port_freeze, // Freeze the serial port state machine.
  output logic port_test_bit, // Test control bit to the serial port.
  output logic irq_level1, // Level 1 (high priority) interrupt request.
  output logic irq_level2 // Level 2 (low priority) interrupt request.
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_ctl;
    logic [7:0] pri_ctl;
    sppc_pkg::sppc_wstate_type wst;
    logic aw_got;
    logic w_got;
    logic [`SPPC_ADDR_W-1:0] awaddr;
    logic awpriv;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    sppc_pkg::sppc_rstate_type rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rx_pin_out;
    logic rx_pin_oe_n;
    logic tx_pin_out;
    logic tx_pin_oe_n;
    logic rx_eng;
    logic freeze;
    logic lvl1;
    logic lvl2;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic bvld;
    logic rvld;
  } sppc_state_type;

  sppc_state_type st_r;
  sppc_state_type st_nxt;
  logic [1:0] pins_sync;
  logic rx_drv_out;
  logic rx_drv_oe_n;
  logic tx_drv_out;
  logic tx_drv_oe_n;

  function automatic logic addr_is(input logic [`SPPC_ADDR_W-1:0] a, input logic [`SPPC_ADDR_W-1:0] reg_addr);
    addr_is = (a[`SPPC_ADDR_W-1:2] == reg_addr[`SPPC_ADDR_W-1:2]);
  endfunction : addr_is

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] mask);
    merge_byte = (old & ~mask) | (nw & mask);
  endfunction : merge_byte

  // ------------------------------------------------------------
  // Pin input synchronisers and pin drivers
  // ------------------------------------------------------------
  sppc_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({transmit_data_pin_in, receive_data_pin_in}),
    .sync_out(pins_sync)
  );

  // The receive pin is input-only in serial mode, so the engine never drives it.
  sppc_pin_drive u_rx_drive (
    .gp_func_n(st_r.pin_ctl[`SPPC_RX_FUNC_BIT]),
    .gp_dir(st_r.pin_ctl[`SPPC_RX_DIR_BIT]),
    .gp_out(st_r.pin_ctl[`SPPC_RX_OUT_BIT]),
    .eng_out(1'b0),
    .eng_oe_n(1'b1),
    .pin_out(rx_drv_out),
    .pin_oe_n(rx_drv_oe_n)
  );

  sppc_pin_drive u_tx_drive (
    .gp_func_n(st_r.pin_ctl[`SPPC_TX_FUNC_BIT]),
    .gp_dir(st_r.pin_ctl[`SPPC_TX_DIR_BIT]),
    .gp_out(st_r.pin_ctl[`SPPC_TX_OUT_BIT]),
    .eng_out(tx_engine_out),
    .eng_oe_n(1'b0),
    .pin_out(tx_drv_out),
    .pin_oe_n(tx_drv_oe_n)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Input bits always reflect the pins, whatever the function.
    st_nxt.pin_ctl[`SPPC_RX_IN_BIT] = pins_sync[0];
    st_nxt.pin_ctl[`SPPC_TX_IN_BIT] = pins_sync[1];

    // Write channel: address and data taken in either order.
    unique case (st_r.wst)
      sppc_pkg::SPPC_W_IDLE: begin
        if (s_axi_awvalid && st_r.aw_rdy) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.awaddr = s_axi_awaddr;
          st_nxt.awpriv = s_axi_awprot[0];
        end
        if (s_axi_wvalid && st_r.w_rdy) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata;
          st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.wst = sppc_pkg::SPPC_W_RESP;
          st_nxt.bresp = `SPPC_RESP_OKAY;
          if (addr_is(st_r.awaddr, `SPPC_PIN_CTL_ADDR)) begin
            if (st_r.wstrb[0]) begin
              st_nxt.pin_ctl = merge_byte(st_nxt.pin_ctl, st_r.wdata[7:0], `SPPC_PIN_RW_MASK);
            end
          end else if (addr_is(st_r.awaddr, `SPPC_PRI_CTL_ADDR)) begin
            // Privilege is the CPU state or the bus privileged attribute.
            if (privileged_mode || st_r.awpriv) begin
              if (st_r.wstrb[0]) begin
                st_nxt.pri_ctl = merge_byte(st_r.pri_ctl, st_r.wdata[7:0], `SPPC_PRI_RW_MASK);
              end
            end
          end else begin
            st_nxt.bresp = `SPPC_RESP_SLVERR;
          end
        end
      end
      sppc_pkg::SPPC_W_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wst = sppc_pkg::SPPC_W_IDLE;
        end
      end
      default: begin
        st_nxt.wst = sppc_pkg::SPPC_W_IDLE;
      end
    endcase

    // Read channel: one cycle from address to data.
    unique case (st_r.rst)
      sppc_pkg::SPPC_R_IDLE: begin
        if (s_axi_arvalid && st_r.ar_rdy) begin
          st_nxt.rst = sppc_pkg::SPPC_R_RESP;
          st_nxt.rresp = `SPPC_RESP_OKAY;
          if (addr_is(s_axi_araddr, `SPPC_PIN_CTL_ADDR)) begin
            st_nxt.rdata = {24'h000000, st_r.pin_ctl};
          end else if (addr_is(s_axi_araddr, `SPPC_PRI_CTL_ADDR)) begin
            st_nxt.rdata = {24'h000000, st_r.pri_ctl[7:4], 4'h0};
          end else begin
            st_nxt.rdata = 32'h00000000;
            st_nxt.rresp = `SPPC_RESP_SLVERR;
          end
        end
      end
      sppc_pkg::SPPC_R_RESP: begin
        if (s_axi_rready) begin
          st_nxt.rst = sppc_pkg::SPPC_R_IDLE;
        end
      end
      default: begin
        st_nxt.rst = sppc_pkg::SPPC_R_IDLE;
      end
    endcase

    // Registered pin drive and receiver feed.
    st_nxt.rx_pin_out = rx_drv_out;
    st_nxt.rx_pin_oe_n = rx_drv_oe_n;
    st_nxt.tx_pin_out = tx_drv_out;
    st_nxt.tx_pin_oe_n = tx_drv_oe_n;
    st_nxt.rx_eng = pins_sync[0];

    // Freeze at once with suspend-enable set, else wait for the sequence to end.
    if (!emu_suspend) begin
      st_nxt.freeze = 1'b0;
    end else if (st_r.pri_ctl[`SPPC_SUSPEND_EN_BIT]) begin
      st_nxt.freeze = 1'b1;
    end else begin
      st_nxt.freeze = st_r.freeze | ~port_busy;
    end

    // Route each request to the level its priority bit selects.
    st_nxt.lvl1 = (rx_irq_req && !st_r.pri_ctl[`SPPC_RXPRI_BIT]) ||
                  (tx_irq_req && !st_r.pri_ctl[`SPPC_TXPRI_BIT]);
    st_nxt.lvl2 = (rx_irq_req && st_r.pri_ctl[`SPPC_RXPRI_BIT]) ||
                  (tx_irq_req && st_r.pri_ctl[`SPPC_TXPRI_BIT]);

    // Handshake flags are registered so every bus output comes from a flop; they stay low through reset.
    st_nxt.aw_rdy = (st_nxt.wst == sppc_pkg::SPPC_W_IDLE) && !st_nxt.aw_got;
    st_nxt.w_rdy = (st_nxt.wst == sppc_pkg::SPPC_W_IDLE) && !st_nxt.w_got;
    st_nxt.ar_rdy = (st_nxt.rst == sppc_pkg::SPPC_R_IDLE);
    st_nxt.bvld = (st_nxt.wst == sppc_pkg::SPPC_W_RESP);
    st_nxt.rvld = (st_nxt.rst == sppc_pkg::SPPC_R_RESP);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.rx_pin_oe_n <= 1'b1;
      st_r.tx_pin_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_bvalid = st_r.bvld;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_rvalid = st_r.rvld;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign receive_data_pin_out = st_r.rx_pin_out;
  assign receive_data_pin_oe_n = st_r.rx_pin_oe_n;
  assign transmit_data_pin_out = st_r.tx_pin_out;
  assign transmit_data_pin_oe_n = st_r.tx_pin_oe_n;
  assign rx_engine_in = st_r.rx_eng;
  assign port_freeze = st_r.freeze;
  assign port_test_bit = st_r.pri_ctl[`SPPC_PORT_TEST_BIT];
  assign irq_level1 = st_r.lvl1;
  assign irq_level2 = st_r.lvl2;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_gp_drive: assert property (
    (!st_r.pin_ctl[1] && st_r.pin_ctl[0]) |=> (!receive_data_pin_oe_n && receive_data_pin_out == $past(st_r.pin_ctl[2])))
    else $error("receive pin not driven with its output bit");
  a_tx_serial_own: assert property (
    st_r.pin_ctl[5] |=> (!transmit_data_pin_oe_n && transmit_data_pin_out == $past(tx_engine_out)))
    else $error("transmitter does not own transmit pin");
  a_tx_gp_drive: assert property (
    (!st_r.pin_ctl[5] && st_r.pin_ctl[4]) |=> (!transmit_data_pin_oe_n && transmit_data_pin_out == $past(st_r.pin_ctl[6])))
    else $error("transmit pin not driven with its output bit");
  a_tx_gp_input: assert property (
    (!st_r.pin_ctl[5] && !st_r.pin_ctl[4]) |=> transmit_data_pin_oe_n)
    else $error("transmit pin driven while general-purpose input");
  a_rx_in_live: assert property (
    ##3 st_r.pin_ctl[3] == $past(receive_data_pin_in, 3))
    else $error("receive input bit does not follow pin");
  a_pri_write_guard: assert property (
    (!(st_r.wst == sppc_pkg::SPPC_W_IDLE && st_r.aw_got && st_r.w_got && (privileged_mode || st_r.awpriv)))
      |=> $stable(st_r.pri_ctl))
    else $error("priority register changed without a privileged write");
  a_finish_seq: assert property (
    (emu_suspend && !st_r.pri_ctl[4] && port_busy && !port_freeze) |=> !port_freeze)
    else $error("port frozen mid sequence with suspend-enable clear");
  a_freeze_now: assert property (
    (emu_suspend && st_r.pri_ctl[4]) |=> port_freeze)
    else $error("port not frozen at suspend");
  a_rx_level: assert property (
    (rx_irq_req && !tx_irq_req) |=> (irq_level1 == !$past(st_r.pri_ctl[5]) && irq_level2 == $past(st_r.pri_ctl[5])))
    else $error("receiver request on wrong level");
  a_tx_level: assert property (
    (tx_irq_req && !rx_irq_req) |=> (irq_level1 == !$past(st_r.pri_ctl[6]) && irq_level2 == $past(st_r.pri_ctl[6])))
    else $error("transmitter request on wrong level");
  a_reserved_zero: assert property (
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("upper read data not zero");
  a_rx_serial_in: assert property (
    st_r.pin_ctl[1] |=> receive_data_pin_oe_n)
    else $error("receive pin driven while owned by receiver");
  a_tx_in_live: assert property (
    ##3 st_r.pin_ctl[7] == $past(transmit_data_pin_in, 3))
    else $error("transmit input bit does not follow pin");

  // A write commits one edge after both halves are held; the answer must follow at once.
  sequence s_wr_commit;
    st_r.wst == sppc_pkg::SPPC_W_IDLE && st_r.aw_got && st_r.w_got;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (
    s_wr_commit |=> s_axi_bvalid)
    else $error("write response not raised after commit");
  a_wr_ready_low: assert property (
    s_wr_commit |-> (!s_axi_awready && !s_axi_wready))
    else $error("write channel ready while a write is held");
  a_rd_answer: assert property (
    s_rd_take |=> s_axi_rvalid)
    else $error("read data not valid after address taken");
  a_rd_unmapped: assert property (
    (s_axi_arvalid && s_axi_arready && !addr_is(s_axi_araddr, `SPPC_PIN_CTL_ADDR) &&
      !addr_is(s_axi_araddr, `SPPC_PRI_CTL_ADDR)) |=> (s_axi_rresp == `SPPC_RESP_SLVERR))
    else $error("unmapped read not answered with an error");
endmodule : sppc_top

// file: test/sppc_top_tb.sv
// Self-checking testbench for the serial pin and priority control block.
`timescale 1ns/1ps
`include "sppc_defs.svh"
module sppc_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [`SPPC_ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic priv, emu, busy, rx_in, rx_out, rx_oe_n, tx_in, tx_out, tx_oe_n, tx_eng, rx_eng, rx_irq, tx_irq;
  logic freeze, test_bit, lvl1, lvl2;
  int n_errors = 0;
  int checks = 0;

  sppc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .privileged_mode(priv), .emu_suspend(emu), .port_busy(busy),
    .receive_data_pin_in(rx_in), .receive_data_pin_out(rx_out), .receive_data_pin_oe_n(rx_oe_n),
    .transmit_data_pin_in(tx_in), .transmit_data_pin_out(tx_out), .transmit_data_pin_oe_n(tx_oe_n),
    .tx_engine_out(tx_eng), .rx_engine_in(rx_eng), .rx_irq_req(rx_irq), .tx_irq_req(tx_irq),
    .port_freeze(freeze), .port_test_bit(test_bit), .irq_level1(lvl1), .irq_level2(lvl2));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Bus and checking helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // Offers address and data together and holds each until its own ready edge.
  task automatic wr(input logic [`SPPC_ADDR_W-1:0] a, input logic [31:0] d, input logic [2:0] p, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awprot <= p;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (!bvalid) begin
      check(32'h0, 32'h1, "write timeout");
      tally_and_finish();
    end
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [`SPPC_ADDR_W-1:0] a, output logic [31:0] d);
    int n;
    logic ar;
    logic [1:0] er;
    n = 0;
    ar = 1'b0;
    er = ((a >> 2) == (`SPPC_PIN_CTL_ADDR >> 2) || (a >> 2) == (`SPPC_PRI_CTL_ADDR >> 2)) ?
      `SPPC_RESP_OKAY : `SPPC_RESP_SLVERR;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready && !ar) begin
        ar = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    d = rdata;
    if (!rvalid) begin
      check(32'h0, 32'h1, "read timeout");
      tally_and_finish();
    end
    check({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_map;
    logic [31:0] d;
    rd(`SPPC_PIN_CTL_ADDR, d);
    check(d, 32'h0, "pin reg reset");
    rd(`SPPC_PRI_CTL_ADDR, d);
    check(d, 32'h0, "priority reg reset");
    check({tx_oe_n, rx_oe_n}, 32'h3, "pins released in reset");
    wr(15'h0200, 32'hFF, 3'h1, `SPPC_RESP_SLVERR);
    rd(15'h0200, d);
    rd(`SPPC_PIN_CTL_ADDR, d);
    check(d, 32'h0, "unmapped write had effect");
    $display("Test reset and map done");
  endtask : t_reset_and_map

  task automatic t_pin_drive;
    wr(`SPPC_PIN_CTL_ADDR, 32'h55, 3'h0, `SPPC_RESP_OKAY);
    tick(2);
    check({rx_out, rx_oe_n}, 32'h2, "rx pin general output");
    check({tx_out, tx_oe_n}, 32'h2, "tx pin general output");
    wr(`SPPC_PIN_CTL_ADDR, 32'h40, 3'h0, `SPPC_RESP_OKAY);
    tick(2);
    check({31'h0, tx_oe_n}, 32'h1, "tx pin general input");
    tx_eng <= 1'b1;
    wr(`SPPC_PIN_CTL_ADDR, 32'h36, 3'h0, `SPPC_RESP_OKAY);
    tick(2);
    check({tx_out, tx_oe_n}, 32'h2, "tx pin engine high");
    check({31'h0, rx_oe_n}, 32'h1, "rx pin owned by receiver");
    tx_eng <= 1'b0;
    tick(3);
    check({tx_out, tx_oe_n}, 32'h0, "tx pin engine low");
    rx_in <= 1'b1;
    tick(5);
    check({31'h0, rx_eng}, 32'h1, "receiver sees pad");
    $display("Test pin drive done");
  endtask : t_pin_drive

  task automatic t_pin_inputs;
    logic [31:0] d;
    rx_in <= 1'b1;
    tx_in <= 1'b0;
    wr(`SPPC_PIN_CTL_ADDR, 32'hFF, 3'h0, `SPPC_RESP_OKAY);
    tick(5);
    rd(`SPPC_PIN_CTL_ADDR, d);
    check(d, 32'h7F, "input bits show pads");
    rx_in <= 1'b0;
    tx_in <= 1'b1;
    tick(5);
    rd(`SPPC_PIN_CTL_ADDR, d);
    check(d, 32'hF7, "input bits follow pads");
    $display("Test pin inputs done");
  endtask : t_pin_inputs

  task automatic t_privilege;
    logic [31:0] d;
    wr(`SPPC_PRI_CTL_ADDR, 32'h6F, 3'h0, `SPPC_RESP_OKAY);
    rd(`SPPC_PRI_CTL_ADDR, d);
    check(d, 32'h0, "unprivileged write ignored");
    priv <= 1'b1;
    wr(`SPPC_PRI_CTL_ADDR, 32'h2F, 3'h0, `SPPC_RESP_OKAY);
    priv <= 1'b0;
    rd(`SPPC_PRI_CTL_ADDR, d);
    check(d, 32'h20, "privileged write, reserved read zero");
    wr(`SPPC_PRI_CTL_ADDR, 32'h40, 3'h1, `SPPC_RESP_OKAY);
    rd(`SPPC_PRI_CTL_ADDR, d);
    check(d, 32'h40, "privileged bus write");
    check({31'h0, test_bit}, 32'h0, "test bit stays clear");
    $display("Test privilege done");
  endtask : t_privilege

  task automatic t_irq_levels;
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      wr(`SPPC_PRI_CTL_ADDR, {25'h0, b, 5'h0}, 3'h1, `SPPC_RESP_OKAY);
      rx_irq <= 1'b1;
      tx_irq <= 1'b0;
      tick(2);
      check({lvl1, lvl2}, {30'h0, !b[0], b[0]}, "receiver request level");
      rx_irq <= 1'b0;
      tx_irq <= 1'b1;
      tick(2);
      check({lvl1, lvl2}, {30'h0, !b[1], b[1]}, "transmitter request level");
      tx_irq <= 1'b0;
    end
    $display("Test interrupt levels done");
  endtask : t_irq_levels

  task automatic t_suspend;
    wr(`SPPC_PRI_CTL_ADDR, 32'h10, 3'h1, `SPPC_RESP_OKAY);
    tick(2);
    check({31'h0, freeze}, 32'h0, "no freeze outside suspend");
    emu <= 1'b1;
    busy <= 1'b1;
    tick(2);
    check({31'h0, freeze}, 32'h1, "freeze at once");
    emu <= 1'b0;
    tick(2);
    wr(`SPPC_PRI_CTL_ADDR, 32'h00, 3'h1, `SPPC_RESP_OKAY);
    emu <= 1'b1;
    tick(5);
    check({31'h0, freeze}, 32'h0, "busy sequence finishes");
    busy <= 1'b0;
    tick(3);
    check({31'h0, freeze}, 32'h1, "freeze after sequence");
    emu <= 1'b0;
    tick(2);
    check({31'h0, freeze}, 32'h0, "freeze ends with suspend");
    $display("Test suspend done");
  endtask : t_suspend

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, priv, emu, busy} = '0;
    {rx_in, tx_in, tx_eng, rx_irq, tx_irq} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_and_map();
    t_pin_drive();
    t_pin_inputs();
    t_privilege();
    t_irq_levels();
    t_suspend();
    tally_and_finish();
  end
endmodule : sppc_top_tb
